// ===== hw/phag_top.sv
// Bus ownership arbiter and peripheral glue: modes, DMA address and
// timing glue, interrupt wiring, timer gate/output routing, selects.
// Assumes standard DMA, interrupt and timer cells sit outside.
//
// How it works
// - Bus owned in one of four modes: CPU, DMA, external master, refresh.
// - Hold grant low always means CPU mode.
// - Other modes only entered while hold grant is high.
// - Either address-enable input active forces DMA mode while hold grant is high.
// - Two 8-bit latches hold middle address; page file gives upper bits.
// - Each DMA cycle gets exactly one forced wait state.
// - DMA memory read leading edge delayed one DMA clock.
// - Eight channels: five 8-bit (0 to 4), three 16-bit (5 to 7).
// - Any channel reaches the whole 16 MB space.
// - Two interrupt cells cascaded for 15 sources.
// - All timer counters clocked at 1.19 MHz.
// - Timer gates 0 and 1 tied high.
// - Gate 2 flop captures data bit 0 on port B write.
// - Counter 0 output drives interrupt request 0.
// - Counter 1 output requests hold and starts refresh.
// - Counter 2 output goes to a pin.
// - Arbiter picks between DMA hold and refresh request, drives refresh line.
// - CPU hold request high whenever DMA or external master wants the bus.
// - Address decode produces a select per sub-cell.
// - Refresh line pulled low after granted refresh; external refresh accepted.
// - Address enable high in DMA cycles, low otherwise.
`timescale 1ns/1ps
`default_nettype none
module phag_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        cpu_hold_grant,
  input  wire logic        dma_hold_req,
  input  wire logic        ext_master_req,
  input  wire logic        dma_addr_enable_first_n,
  input  wire logic        dma_addr_enable_second_n,
  input  wire logic [2:0]  dma_chan,
  input  wire logic [7:0]  dma_addr_low,
  input  wire logic [7:0]  dma_mid_data,
  input  wire logic        dma_mid_load_first,
  input  wire logic        dma_mid_load_second,
  input  wire logic        dma_cycle_start,
  input  wire logic        dma_mem_read_req_n,
  input  wire logic        cpu_mem_read_n,
  input  wire logic [13:0] irq_src,
  input  wire logic        sec_cell_int,
  input  wire logic        tmr_out0,
  input  wire logic        tmr_out1,
  input  wire logic        tmr_out2,
  input  wire logic [9:0]  pio_addr,
  input  wire logic        pio_wr,
  input  wire logic [7:0]  pd_data,
  input  wire logic        refresh_line_n_in,
  output var  logic        cpu_hold_request,
  output var  logic        internal_hold_grant,
  output var  logic        ext_master_grant,
  output var  logic [3:0]  bus_mode,
  output var  logic        addr_enable,
  output var  logic [23:0] dma_addr,
  output var  logic        dma_ready,
  output var  logic        memory_read_strobe_n,
  output var  logic [7:0]  irq_primary,
  output var  logic [7:0]  irq_secondary,
  output var  logic        tmr_clk_en,
  output var  logic [2:0]  tmr_gate,
  output var  logic        tone_out,
  output var  logic [phag_pkg::NUM_CS-1:0] cell_sel,
  output var  logic        refresh_line_n_out,
  output var  logic        refresh_line_n_oe
);
  import phag_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0]        rst_sync_ff;
  logic              rst_n;
  logic              dma_tick;
  phag_mode_t        bus_mode_ff;
  phag_mode_t        nxt_mode;
  phag_mode_t        pick_mode;
  logic              aen_act;
  logic              refr_done;
  logic              refr_set;
  logic              refr_pend_ff;
  logic [2:0]        refr_cnt_ff;
  logic              tmr1_d_ff;
  logic              refr_in_d_ff;
  logic              cpu_hold_request_ff;
  logic              int_grant_ff;
  logic              ext_grant_ff;
  logic              addr_enable_ff;
  logic              refr_oe_ff;
  logic              refr_out_ff;
  logic              dma_ready_ff;
  logic              rd_strobe_ff;
  logic              rd_arm_ff;
  logic [7:0]        mid_first_ff;
  logic [7:0]        mid_second_ff;
  logic [7:0]        page_ff [PAGE_DEPTH];
  logic [7:0]        page_sel;
  logic [23:0]       dma_addr_ff;
  logic [7:0]        irq_pri_ff;
  logic [7:0]        irq_sec_ff;
  logic [2:0]        tmr_gate_ff;
  logic              tone_ff;
  logic [NUM_CS-1:0] cs_hit;
  logic [NUM_CS-1:0] cell_sel_ff;

  // ----------------------------------------
  // Reset release and clock enables
  // ----------------------------------------
  // Release through two flops so no flop sees a ragged reset edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Timer count enable
  phag_tick_div #(.DIV(TMR_DIV)) u_tmr_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick_ff (tmr_clk_en)
  );

  // DMA clock enable paces wait states, read delay and refresh length
  phag_tick_div #(.DIV(DMA_DIV)) u_dma_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .tick_ff (dma_tick)
  );

  // ----------------------------------------
  // Mode arbitration
  // ----------------------------------------
  assign aen_act   = !dma_addr_enable_first_n || !dma_addr_enable_second_n;
  assign refr_done = (refr_cnt_ff == REFR_TICKS);
  // Refresh from counter 1 rising or from an outside source pulling the line
  assign refr_set  = (tmr_out1 && !tmr1_d_ff)
                  || (refr_in_d_ff && !refresh_line_n_in && !refr_oe_ff);

  // Refresh first so memory never starves, then DMA, then external master
  always_comb begin
    if (refr_pend_ff) begin
      pick_mode = MODE_REFR;
    end else if (dma_hold_req) begin
      pick_mode = MODE_DMA;
    end else if (ext_master_req) begin
      pick_mode = MODE_EXTM;
    end else begin
      pick_mode = MODE_CPU;
    end
  end

  // Next mode; refresh and external master cycles run to their end unless hold grant drops or address enable forces DMA
  always_comb begin
    nxt_mode = bus_mode_ff;
    if (!cpu_hold_grant) begin
      nxt_mode = MODE_CPU;
    end else if (aen_act) begin
      nxt_mode = MODE_DMA;
    end else begin
      case (bus_mode_ff)
        MODE_REFR: if (refr_done) nxt_mode = pick_mode;
        MODE_EXTM: if (!ext_master_req) nxt_mode = pick_mode;
        MODE_CPU:  nxt_mode = pick_mode;
        MODE_DMA:  nxt_mode = pick_mode;
        default:   nxt_mode = MODE_CPU;
      endcase
    end
  end

  // Mode register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_mode_ff <= MODE_CPU;
    end else begin
      bus_mode_ff <= nxt_mode;
    end
  end

  // Refresh pending; a new request wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refr_pend_ff <= 1'b0;
      tmr1_d_ff    <= 1'b0;
      refr_in_d_ff <= 1'b1;
    end else begin
      tmr1_d_ff    <= tmr_out1;
      refr_in_d_ff <= refresh_line_n_in;
      if (refr_set) begin
        refr_pend_ff <= 1'b1;
      end else if (nxt_mode == MODE_REFR && bus_mode_ff != MODE_REFR) begin
        refr_pend_ff <= 1'b0;
      end
    end
  end

  // Refresh length in DMA clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refr_cnt_ff <= 3'h0;
    end else if (bus_mode_ff != MODE_REFR) begin
      refr_cnt_ff <= 3'h0;
    end else if (dma_tick && !refr_done) begin
      refr_cnt_ff <= refr_cnt_ff + 3'h1;
    end
  end

  // Hold request and grants; hold stays up until every requester is gone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_hold_request_ff <= 1'b0;
      int_grant_ff        <= 1'b0;
      ext_grant_ff        <= 1'b0;
      addr_enable_ff      <= 1'b0;
    end else begin
      cpu_hold_request_ff <= dma_hold_req || ext_master_req
                          || refr_set || refr_pend_ff
                          || (bus_mode_ff == MODE_REFR && !refr_done);
      int_grant_ff        <= cpu_hold_grant && nxt_mode == MODE_DMA;
      ext_grant_ff        <= cpu_hold_grant && nxt_mode == MODE_EXTM;
      addr_enable_ff      <= (nxt_mode == MODE_DMA);
    end
  end

  // Open-drain refresh line, driven low only in refresh mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refr_oe_ff  <= 1'b0;
      refr_out_ff <= 1'b1;
    end else begin
      refr_oe_ff  <= (nxt_mode == MODE_REFR);
      refr_out_ff <= (nxt_mode != MODE_REFR);
    end
  end

  // ----------------------------------------
  // DMA timing glue
  // ----------------------------------------
  // Ready drops at cycle start and returns on the next DMA clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_ready_ff <= 1'b1;
    end else if (dma_cycle_start && bus_mode_ff == MODE_DMA) begin
      dma_ready_ff <= 1'b0;
    end else if (dma_tick) begin
      dma_ready_ff <= 1'b1;
    end
  end

  // Memory read: leading edge held a full DMA clock, trailing edge at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_strobe_ff <= 1'b1;
      rd_arm_ff    <= 1'b0;
    end else begin
      case (bus_mode_ff)
        MODE_DMA: begin
          if (dma_mem_read_req_n) begin
            rd_strobe_ff <= 1'b1;
            rd_arm_ff    <= 1'b0;
          end else if (dma_tick) begin
            rd_arm_ff <= 1'b1;
            if (rd_arm_ff) rd_strobe_ff <= 1'b0;
          end
        end
        MODE_REFR: begin
          rd_strobe_ff <= 1'b0;
          rd_arm_ff    <= 1'b0;
        end
        default: begin
          rd_strobe_ff <= cpu_mem_read_n;
          rd_arm_ff    <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // DMA address extension
  // ----------------------------------------
  // Middle-byte latches, one per DMA cell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mid_first_ff  <= 8'h00;
      mid_second_ff <= 8'h00;
    end else begin
      if (dma_mid_load_first)  mid_first_ff  <= dma_mid_data;
      if (dma_mid_load_second) mid_second_ff <= dma_mid_data;
    end
  end

  // Page file, written by CPU I/O through its select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PAGE_DEPTH; i++) page_ff[i] <= 8'h00;
    end else if (pio_wr && cs_hit[CS_PAGE] && !addr_enable_ff) begin
      page_ff[pio_addr[3:0]] <= pd_data;
    end
  end
  assign page_sel = page_ff[{1'b0, dma_chan}];

  // Word channels shift by one; page bit 0 is lost there, as on a real AT
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_addr_ff <= 24'h00_0000;
    end else if (dma_chan >= CHAN_WIDE_MIN) begin
      dma_addr_ff <= {page_sel[7:1], mid_second_ff, dma_addr_low, 1'b0};
    end else begin
      dma_addr_ff <= {page_sel, mid_first_ff, dma_addr_low};
    end
  end

  // ----------------------------------------
  // Interrupt wiring and timer routing
  // ----------------------------------------
  // Secondary cell output enters primary input 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pri_ff <= 8'h00;
      irq_sec_ff <= 8'h00;
    end else begin
      irq_pri_ff <= {irq_src[5:1], sec_cell_int, irq_src[0], tmr_out0};
      irq_sec_ff <= irq_src[13:6];
    end
  end

  // Gates 0 and 1 fixed; gate 2 from the port B write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_gate_ff <= GATE_RST;
      tone_ff     <= 1'b0;
    end else begin
      tmr_gate_ff[1:0] <= 2'b11;
      if (pio_wr && cs_hit[CS_PORTB] && !addr_enable_ff) begin
        tmr_gate_ff[2] <= pd_data[0];
      end
      tone_ff <= tmr_out2;
    end
  end

  // ----------------------------------------
  // Sub-cell selects
  // ----------------------------------------
  // Decode suppressed during DMA so the cells ignore DMA addresses
  for (genvar gi = 0; gi < NUM_CS; gi++) begin : g_cs
    assign cs_hit[gi] = ((pio_addr & CS_MASK[gi]) == CS_BASE[gi]);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cell_sel_ff <= '0;
    end else begin
      cell_sel_ff <= addr_enable_ff ? '0 : cs_hit;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cpu_hold_request     = cpu_hold_request_ff;
  assign internal_hold_grant  = int_grant_ff;
  assign ext_master_grant     = ext_grant_ff;
  assign bus_mode             = bus_mode_ff;
  assign addr_enable          = addr_enable_ff;
  assign dma_addr             = dma_addr_ff;
  assign dma_ready            = dma_ready_ff;
  assign memory_read_strobe_n = rd_strobe_ff;
  assign irq_primary          = irq_pri_ff;
  assign irq_secondary        = irq_sec_ff;
  assign tmr_gate             = tmr_gate_ff;
  assign tone_out             = tone_ff;
  assign cell_sel             = cell_sel_ff;
  assign refresh_line_n_out   = refr_out_ff;
  assign refresh_line_n_oe    = refr_oe_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence granted_idle_s;
    cpu_hold_grant && !aen_act && bus_mode_ff == MODE_CPU;
  endsequence

  sequence dma_start_s;
    dma_cycle_start && bus_mode_ff == MODE_DMA;
  endsequence

  cpu_mode_a: assert property (!cpu_hold_grant |=> bus_mode_ff == MODE_CPU)
    else $error("not in CPU mode after grant low");
  held_mode_a: assert property (bus_mode_ff != MODE_CPU |-> $past(cpu_hold_grant))
    else $error("non-CPU mode without hold grant");
  aen_dma_a: assert property (cpu_hold_grant && aen_act |=> bus_mode_ff == MODE_DMA)
    else $error("address enable did not force DMA mode");
  addr_en_a: assert property (addr_enable_ff == (bus_mode_ff == MODE_DMA))
    else $error("address enable disagrees with mode");
  wait_state_a: assert property (dma_start_s ##1 !dma_tick |=> !dma_ready_ff)
    else $error("DMA wait state too short");
  wait_end_a: assert property (dma_start_s |-> ##[1:30] dma_ready_ff)
    else $error("DMA wait state not ended");
  read_delay_a: assert property ($fell(rd_strobe_ff) && $past(bus_mode_ff) == MODE_DMA
    |-> $past(dma_tick) && $past(rd_arm_ff))
    else $error("DMA memory read not delayed");
  gate_two_a: assert property (pio_wr && cs_hit[CS_PORTB] && !addr_enable_ff
    |=> tmr_gate_ff[2] == $past(pd_data[0]))
    else $error("gate 2 did not capture data bit 0");
  gate_tied_a: assert property (tmr_gate_ff[1:0] == 2'b11)
    else $error("gates 0 and 1 not high");
  irq_zero_a: assert property (irq_pri_ff[0] == $past(tmr_out0))
    else $error("counter 0 not on request 0");
  hold_req_a: assert property (dma_hold_req || ext_master_req |=> cpu_hold_request_ff)
    else $error("hold request missing");
  refr_hold_a: assert property ($rose(tmr_out1) |=> cpu_hold_request_ff)
    else $error("counter 1 did not request hold");
  refr_pick_a: assert property (granted_idle_s and refr_pend_ff |=> bus_mode_ff == MODE_REFR)
    else $error("refresh not chosen first");
  refr_drive_a: assert property (refr_oe_ff |-> bus_mode_ff == MODE_REFR
    && !refr_out_ff && $past(cpu_hold_grant))
    else $error("refresh line driven outside refresh");

endmodule
`default_nettype wire

// ===== hw/phag_pkg.sv
// Constants and types for the peripheral hold arbiter and glue block.
// Assumes a single 100 MHz system clock; slower rates are enable pulses.
package phag_pkg;

  // ----------------------------------------
  // Clock rates and dividers
  // ----------------------------------------
  localparam int CLK_KHZ      = 100000;
  localparam int TMR_RATE_KHZ = 1190;
  localparam int TMR_DIV      = CLK_KHZ / TMR_RATE_KHZ;
  localparam int DMA_RATE_KHZ = 5000;
  localparam int DMA_DIV      = CLK_KHZ / DMA_RATE_KHZ;

  // ----------------------------------------
  // Bus modes, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    MODE_CPU  = 4'h1,
    MODE_DMA  = 4'h2,
    MODE_EXTM = 4'h4,
    MODE_REFR = 4'h8
  } phag_mode_t;

  // ----------------------------------------
  // Counts and reset values
  // ----------------------------------------
  localparam logic [2:0] REFR_TICKS    = 3'h4;
  localparam logic [2:0] GATE_RST      = 3'h3;
  localparam logic [2:0] CHAN_WIDE_MIN = 3'h5;
  localparam int         PAGE_DEPTH    = 16;

  // ----------------------------------------
  // Sub-cell select decode
  // ----------------------------------------
  localparam int NUM_CS   = 7;
  localparam int CS_DMA1  = 0;
  localparam int CS_PIC1  = 1;
  localparam int CS_TMR   = 2;
  localparam int CS_PORTB = 3;
  localparam int CS_PAGE  = 4;
  localparam int CS_PIC2  = 5;
  localparam int CS_DMA2  = 6;
  localparam logic [9:0] CS_BASE [NUM_CS] = '{10'h000, 10'h020, 10'h040, 10'h061,
                                              10'h080, 10'h0A0, 10'h0C0};
  localparam logic [9:0] CS_MASK [NUM_CS] = '{10'h3E0, 10'h3E0, 10'h3E0, 10'h3FF,
                                              10'h3F0, 10'h3E0, 10'h3E0};

endpackage

// ===== hw/phag_tick_div.sv
// Enable-pulse divider: one-cycle pulse every DIV clocks.
// Assumes rst_n is already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
module phag_tick_div #(
  parameter int DIV = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic tick_ff
);
  import phag_pkg::*;

  logic [7:0] cnt_ff;

  // Free-running count, pulse on wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b0;
    end else if (cnt_ff == 8'(DIV - 1)) begin
      cnt_ff  <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 8'h01;
      tick_ff <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verification/phag_cpu_model.sv
// CPU side of the bus hold handshake for the glue block.
// Assumes the block samples the grant on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module phag_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] grant_delay,
  input  wire logic       cpu_hold_request,
  output var  logic       cpu_hold_grant
);
  logic [3:0] wait_ff;

  // Grants after a chosen delay; drops the grant as soon as hold falls
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff        <= 4'h0;
      cpu_hold_grant <= 1'b0;
    end else if (!cpu_hold_request) begin
      wait_ff        <= 4'h0;
      cpu_hold_grant <= 1'b0;
    end else if (wait_ff >= grant_delay) begin
      cpu_hold_grant <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the hold arbiter and peripheral glue.
// Assumes the CPU model file is compiled first; inputs move at negedge.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import phag_pkg::*;
  logic clk, arst_n, grant, dma_req, ext_req, aen1_n, aen2_n, ld1, ld2, start;
  logic rd_n, t0, t1, t2, wr, sec_int, ext_refr_n, wire_n, hreq, ihg, emg, aen;
  logic ready, strobe_n, clk_en, tone, r_out, r_oe, cpu_rd_n;
  logic [2:0]  chan, gate;
  logic [3:0]  mode, gdly;
  logic [7:0]  low, mid, pd, irq_p, irq_s;
  logic [9:0]  addr;
  logic [13:0] irq;
  logic [23:0] daddr;
  logic [6:0]  sel;
  int          fail_count, n_compared;

  // ----------------------------------------
  // Clock, pull-up refresh wire, design and CPU
  // ----------------------------------------
  always #5 clk = ~clk;
  assign wire_n = (r_oe ? r_out : 1'b1) & ext_refr_n;
  phag_top u_phag_top (.clk(clk), .arst_n(arst_n), .cpu_hold_grant(grant),
    .dma_hold_req(dma_req), .ext_master_req(ext_req), .dma_addr_enable_first_n(aen1_n),
    .dma_addr_enable_second_n(aen2_n), .dma_chan(chan), .dma_addr_low(low),
    .dma_mid_data(mid), .dma_mid_load_first(ld1), .dma_mid_load_second(ld2),
    .dma_cycle_start(start), .dma_mem_read_req_n(rd_n), .cpu_mem_read_n(cpu_rd_n),
    .irq_src(irq), .sec_cell_int(sec_int), .tmr_out0(t0), .tmr_out1(t1), .tmr_out2(t2),
    .pio_addr(addr), .pio_wr(wr), .pd_data(pd), .refresh_line_n_in(wire_n),
    .cpu_hold_request(hreq), .internal_hold_grant(ihg), .ext_master_grant(emg),
    .bus_mode(mode), .addr_enable(aen), .dma_addr(daddr), .dma_ready(ready),
    .memory_read_strobe_n(strobe_n), .irq_primary(irq_p), .irq_secondary(irq_s),
    .tmr_clk_en(clk_en), .tmr_gate(gate), .tone_out(tone), .cell_sel(sel),
    .refresh_line_n_out(r_out), .refresh_line_n_oe(r_oe));
  phag_cpu_model u_phag_cpu_model (.clk(clk), .rst_n(arst_n), .grant_delay(gdly),
    .cpu_hold_request(hreq), .cpu_hold_grant(grant));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait for a bus mode, so a stuck arbiter cannot hang the run
  task automatic wait_mode(input logic [3:0] m);
    for (int i = 0; i < 150 && mode !== m; i++) cyc(1);
    check("bus_mode", 24'(mode), 24'(m));
  endtask
  task automatic pio_write(input logic [9:0] a, input logic [7:0] d);
    addr = a;
    pd   = d;
    wr   = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_glue;
    int per;
    check("gate_rst", 24'(gate), 24'h3);
    check("mode_rst", 24'(mode), 24'(MODE_CPU));
    pio_write(10'h061, 8'h01);
    check("gate_on", 24'(gate), 24'h7);
    pio_write(10'h061, 8'hFE); // Bit 0 only, other bits set
    check("gate_off", 24'(gate), 24'h3);
    addr = 10'h061;
    cyc(2);
    check("sel_portb", 24'(sel), 24'h08);
    irq = 14'h2A5B;
    sec_int = 1'b1;
    t0 = 1'b1;
    t2 = 1'b1;
    cyc(2);
    check("irq_p", 24'(irq_p), 24'({irq[5:1], 1'b1, irq[0], 1'b1}));
    check("irq_s", 24'(irq_s), 24'(irq[13:6]));
    check("irq0", 24'(irq_p[0]), 24'h1);
    check("tone", 24'(tone), 24'h1);
    t2 = 1'b0;
    cyc(2);
    check("tone_lo", 24'(tone), 24'h0);
    cpu_rd_n = 1'b0; // CPU read passes straight through in CPU mode
    cyc(2);
    check("cpu_read_lo", 24'(strobe_n), 24'h0);
    cpu_rd_n = 1'b1;
    cyc(2);
    check("cpu_read_hi", 24'(strobe_n), 24'h1);
    for (int i = 0; i < 100 && clk_en !== 1'b1; i++) cyc(1);
    cyc(1);
    // A missing second pulse must still end in a compare
    per = 0;
    for (int i = 1; i < 200 && per == 0; i++) begin
      if (clk_en === 1'b1) begin
        per = i;
      end else begin
        cyc(1);
      end
    end
    check("tmr_period", 24'(per), 24'(TMR_DIV));
    $display("Test glue done");
  endtask

  task automatic t_dma;
    int n;
    pio_write(10'h081, 8'hA5); // Page entries for a byte and a word channel
    pio_write(10'h085, 8'h3C);
    dma_req = 1'b1;
    cyc(3);
    check("hold_req", 24'(hreq), 24'h1);
    check("no_grant_cpu", 24'(mode), 24'(MODE_CPU));
    aen1_n = 1'b0;
    wait_mode(MODE_DMA);
    check("int_grant", 24'(ihg), 24'h1);
    check("aen_dma", 24'(aen), 24'h1);
    chan = 3'h1;
    mid  = 8'h5A;
    low  = 8'hC3;
    ld1  = 1'b1;
    cyc(1);
    ld1 = 1'b0;
    cyc(2);
    check("addr_byte", daddr, 24'hA5_5AC3);
    chan = 3'h5;
    mid  = 8'h96;
    ld2  = 1'b1;
    cyc(1);
    ld2 = 1'b0;
    cyc(2);
    check("addr_word", daddr, {7'h1E, 8'h96, 8'hC3, 1'b0});
    start = 1'b1;
    cyc(1);
    start = 1'b0;
    check("wait_state", 24'(ready), 24'h0);
    for (n = 1; n < 30 && ready !== 1'b1; n++) cyc(1);
    check("wait_len", 24'(n <= DMA_DIV + 1), 24'h1);
    rd_n = 1'b0;
    for (n = 0; n < 50 && strobe_n !== 1'b0; n++) cyc(1);
    check("rd_delay", 24'(n >= DMA_DIV - 1 && n <= 2 * DMA_DIV + 2), 24'h1);
    rd_n = 1'b1;
    dma_req = 1'b0;
    aen1_n = 1'b1;
    wait_mode(MODE_CPU);
    cyc(2);
    check("hold_rel", 24'(hreq), 24'h0);
    check("aen_cpu", 24'(aen), 24'h0);
    $display("Test dma done");
  endtask

  task automatic t_ext_refresh;
    gdly = 4'h0;
    ext_req = 1'b1;
    wait_mode(MODE_EXTM);
    check("ext_grant", 24'(emg), 24'h1);
    ext_req = 1'b0;
    wait_mode(MODE_CPU);
    // Refresh and DMA ask together; refresh must win the first slot
    t1 = 1'b1;
    dma_req = 1'b1;
    for (int i = 0; i < 40 && mode === MODE_CPU; i++) cyc(1);
    check("first_owner", 24'(mode), 24'(MODE_REFR));
    check("refr_drive", 24'({r_oe, wire_n}), 24'h2);
    aen2_n = 1'b0;
    wait_mode(MODE_DMA);
    check("refr_off", 24'(r_oe), 24'h0);
    dma_req = 1'b0;
    aen2_n = 1'b1;
    t1 = 1'b0;
    wait_mode(MODE_CPU);
    ext_refr_n = 1'b0; // Refresh timing from an outside source
    cyc(2);
    ext_refr_n = 1'b1;
    wait_mode(MODE_REFR);
    wait_mode(MODE_CPU);
    $display("Test ext_refresh done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    {clk, arst_n, dma_req, ext_req, ld1, ld2, start, t0, t1, t2, wr, sec_int} = '0;
    {aen1_n, aen2_n, rd_n, ext_refr_n, cpu_rd_n} = 5'h1F;
    {chan, low, mid, pd, addr, irq} = '0;
    gdly = 4'h6;
    fail_count = 0;
    n_compared = 0;
    cyc(3);
    arst_n = 1'b1;
    cyc(3);
    t_glue();
    t_dma();
    t_ext_refresh();
    report_and_stop();
  end
  // Whole run is under a thousand cycles; this leaves ample margin
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
